// >>> hw/twowire_master_receiver.sv
// two-wire master receiver engine with apb register file
// assumes open-drain pads outside and an apb master on sys_clk
//
// Contract
// - master mode starts only after this block has driven a START
// - read bit of address byte selects receive, write bit selects transmit
// - requested START waits until the bus is seen free
// - after START the done flag sets and status reads 0x08
// - writing one clears done and lets the engine continue; zero keeps it
// - after address byte and acknowledge, done sets with 0x38, 0x40 or 0x48
// - each received byte is readable from data register while done is set
// - a receive ends with STOP or repeated START from the master
// - ack enable 1 returns ACK after next byte, 0 returns NOT ACK
// - status 0x50 after returned ACK, 0x58 after returned NOT ACK
// - arbitration lost in address or NOT ACK gives 0x38, bus released
// - stop request bit clears itself once STOP is on the bus
//
// Added by the designer: the register offsets and the APB register port.
module twowire_master_receiver
    import twowire_pkg::*;
#(
    parameter int QUARTER = QUARTER_CYCLES
) (
    input  wire logic     sys_clk,
    input  wire logic     rstn,
    input  wire apb_req_t apbReq,
    output apb_rsp_t      apbRsp,
    input  wire logic     sclIn,
    input  wire logic     sdaIn,
    output pad_out_t      pads,
    output logic          irq
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        fsm_t             fsm;
        logic [1:0]       phase;
        logic [2:0]       bitCnt;
        logic             done;
        logic             ackEn;
        logic             sta;
        logic             sto;
        logic             wcol;
        logic             en;
        logic             ie;
        logic [7:0]       status;
        logic [7:0]       shift;
        logic             rxMode;
        logic             addrByte;
        logic             ackOut;
        logic             owner;
        logic             busy;
        logic             sclPull;
        logic             sdaPull;
        logic             sclPrev;
        logic             sdaPrev;
        logic [IRQ_W-1:0] irqStat;
        logic [IRQ_W-1:0] irqMask;
        logic [31:0]      prdata;
    } state_t;

    state_t s_ff;
    state_t nxt_s;

    logic [1:0] pinSync;
    logic       sclS;
    logic       sdaS;
    logic       tick;

    pin_sync #(
        .WIDTH (2),
        .INIT  (2'b11)
    ) u_sync (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .pinIn   ({sclIn, sdaIn}),
        .pinOut  (pinSync)
    );

    tick_divider #(
        .DIV (QUARTER)
    ) u_tick (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .tick    (tick)
    );

    assign sclS = pinSync[1];
    assign sdaS = pinSync[0];

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    function automatic logic isMapped(input logic [ADDR_W-1:0] a);
        return (a == ADDR_CONTROL) || (a == ADDR_STATUS) || (a == ADDR_DATA)
            || (a == ADDR_IRQ_STAT) || (a == ADDR_IRQ_MASK);
    endfunction

    function automatic logic [7:0] ctlByte(input state_t st);
        logic [7:0] v;
        v            = 8'h00;
        v[CTL_DONE]  = st.done;
        v[CTL_ACKEN] = st.ackEn;
        v[CTL_START] = st.sta;
        v[CTL_STOP]  = st.sto;
        v[CTL_WCOL]  = st.wcol;
        v[CTL_EN]    = st.en;
        v[CTL_IE]    = st.ie;
        return v;
    endfunction

    logic       access;
    logic       wrAcc;
    logic       setDone;
    logic       arbLost;
    logic       stopDone;
    logic       startSeen;
    logic       stopSeen;
    logic [7:0] doneCode;

    assign access    = apbReq.psel && apbReq.penable;
    assign wrAcc     = access && apbReq.pwrite && isMapped(apbReq.paddr);
    assign startSeen = sclS && s_ff.sdaPrev && !sdaS;
    assign stopSeen  = sclS && !s_ff.sdaPrev && sdaS;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        nxt_s    = s_ff;
        setDone  = 1'b0;
        arbLost  = 1'b0;
        stopDone = 1'b0;
        doneCode = SC_NO_INFO;

        nxt_s.sclPrev = sclS;
        nxt_s.sdaPrev = sdaS;
        if (startSeen) begin
            nxt_s.busy = 1'b1;
        end else if (stopSeen) begin
            nxt_s.busy = 1'b0;
        end

        // read data captured in setup phase so prdata comes from a flop
        if (apbReq.psel && !apbReq.penable) begin
            case (apbReq.paddr)
                ADDR_CONTROL:  nxt_s.prdata = {24'h00_0000, ctlByte(s_ff)};
                ADDR_STATUS:   nxt_s.prdata = {24'h00_0000, s_ff.status};
                ADDR_DATA:     nxt_s.prdata = {24'h00_0000, s_ff.shift};
                ADDR_IRQ_STAT: nxt_s.prdata = {29'h0000_0000, s_ff.irqStat};
                ADDR_IRQ_MASK: nxt_s.prdata = {29'h0000_0000, s_ff.irqMask};
                default:       nxt_s.prdata = 32'h0000_0000;
            endcase
        end

        // software writes first; hardware sets below override them
        if (wrAcc) begin
            case (apbReq.paddr)
                ADDR_CONTROL: begin
                    if (apbReq.pwdata[CTL_DONE]) begin
                        nxt_s.done = 1'b0;
                    end
                    nxt_s.ackEn = apbReq.pwdata[CTL_ACKEN];
                    nxt_s.sta   = apbReq.pwdata[CTL_START];
                    nxt_s.sto   = apbReq.pwdata[CTL_STOP];
                    nxt_s.en    = apbReq.pwdata[CTL_EN];
                    nxt_s.ie    = apbReq.pwdata[CTL_IE];
                end
                ADDR_DATA: begin
                    // loading the shifter mid-byte would corrupt the bus
                    if (s_ff.done) begin
                        nxt_s.shift = apbReq.pwdata[7:0];
                        nxt_s.wcol  = 1'b0;
                    end else begin
                        nxt_s.wcol = 1'b1;
                    end
                end
                ADDR_IRQ_STAT: nxt_s.irqStat = s_ff.irqStat & ~apbReq.pwdata[IRQ_W-1:0];
                ADDR_IRQ_MASK: nxt_s.irqMask = apbReq.pwdata[IRQ_W-1:0];
                default: ;
            endcase
        end

        // bus engine; one phase per quarter-bit tick
        case (s_ff.fsm)
            FSM_IDLE: begin
                nxt_s.sclPull = 1'b0;
                nxt_s.sdaPull = 1'b0;
                nxt_s.owner   = 1'b0;
                if (s_ff.en && s_ff.sta && !s_ff.done && !s_ff.busy) begin
                    nxt_s.fsm   = FSM_START;
                    nxt_s.phase = 2'd0;
                end
            end
            FSM_START: if (tick) begin
                case (s_ff.phase)
                    2'd0: begin
                        nxt_s.sdaPull = 1'b0;
                        nxt_s.phase   = 2'd1;
                    end
                    2'd1: begin
                        nxt_s.sclPull = 1'b0;
                        if (sclS && sdaS) begin
                            nxt_s.phase = 2'd2;
                        end
                    end
                    2'd2: begin
                        nxt_s.sdaPull = 1'b1;
                        nxt_s.phase   = 2'd3;
                    end
                    default: begin
                        nxt_s.sclPull = 1'b1;
                        nxt_s.owner   = 1'b1;
                        nxt_s.fsm     = FSM_HOLD;
                        nxt_s.phase   = 2'd0;
                        setDone       = 1'b1;
                        doneCode      = s_ff.owner ? SC_RSTART : SC_START;
                    end
                endcase
            end
            FSM_HOLD: begin
                // clock held low until software clears done
                if (!s_ff.done) begin
                    nxt_s.phase = 2'd0;
                    if (s_ff.sto) begin
                        nxt_s.fsm = FSM_STOP;
                    end else if (s_ff.sta) begin
                        nxt_s.fsm = FSM_START;
                    end else if (s_ff.status == SC_START || s_ff.status == SC_RSTART) begin
                        nxt_s.fsm      = FSM_TXB;
                        nxt_s.rxMode   = s_ff.shift[0];
                        nxt_s.addrByte = 1'b1;
                        nxt_s.bitCnt   = 3'd7;
                    end else if (s_ff.status == SC_AR_ACK || s_ff.status == SC_RX_ACK) begin
                        nxt_s.fsm    = FSM_RXB;
                        nxt_s.ackOut = s_ff.ackEn;
                        nxt_s.bitCnt = 3'd7;
                    end else if (!s_ff.rxMode && s_ff.status != SC_NO_INFO) begin
                        nxt_s.fsm      = FSM_TXB;
                        nxt_s.addrByte = 1'b0;
                        nxt_s.bitCnt   = 3'd7;
                    end
                end
            end
            FSM_TXB, FSM_RXB: if (tick) begin
                case (s_ff.phase)
                    2'd0: begin
                        nxt_s.sdaPull = (s_ff.fsm == FSM_TXB) && !s_ff.shift[s_ff.bitCnt];
                        nxt_s.phase   = 2'd1;
                    end
                    2'd1: begin
                        nxt_s.sclPull = 1'b0;
                        nxt_s.phase   = 2'd2;
                    end
                    2'd2: if (sclS) begin
                        nxt_s.phase = 2'd3;
                        if (s_ff.fsm == FSM_RXB) begin
                            nxt_s.shift = {s_ff.shift[6:0], sdaS};
                        end else if (!s_ff.sdaPull && !sdaS) begin
                            arbLost = 1'b1;
                        end
                    end
                    default: begin
                        nxt_s.sclPull = 1'b1;
                        nxt_s.phase   = 2'd0;
                        nxt_s.bitCnt  = s_ff.bitCnt - 3'd1;
                        if (s_ff.bitCnt == 3'd0) begin
                            nxt_s.fsm = (s_ff.fsm == FSM_TXB) ? FSM_TACK : FSM_RACK;
                        end
                    end
                endcase
            end
            FSM_TACK, FSM_RACK: if (tick) begin
                case (s_ff.phase)
                    2'd0: begin
                        nxt_s.sdaPull = (s_ff.fsm == FSM_RACK) && s_ff.ackOut;
                        nxt_s.phase   = 2'd1;
                    end
                    2'd1: begin
                        nxt_s.sclPull = 1'b0;
                        nxt_s.phase   = 2'd2;
                    end
                    2'd2: if (sclS) begin
                        nxt_s.phase  = 2'd3;
                        nxt_s.ackOut = (s_ff.fsm == FSM_TACK) ? !sdaS : s_ff.ackOut;
                        if (s_ff.fsm == FSM_RACK && !s_ff.ackOut && !sdaS) begin
                            arbLost = 1'b1;
                        end
                    end
                    default: begin
                        nxt_s.sclPull = 1'b1;
                        nxt_s.sdaPull = 1'b0;
                        nxt_s.phase   = 2'd0;
                        nxt_s.fsm     = FSM_HOLD;
                        setDone       = 1'b1;
                        if (s_ff.fsm == FSM_RACK) begin
                            doneCode = s_ff.ackOut ? SC_RX_ACK : SC_RX_NACK;
                        end else if (s_ff.addrByte && s_ff.rxMode) begin
                            doneCode = s_ff.ackOut ? SC_AR_ACK : SC_AR_NACK;
                        end else if (s_ff.addrByte) begin
                            doneCode = s_ff.ackOut ? SC_AW_ACK : SC_AW_NACK;
                        end else begin
                            doneCode = s_ff.ackOut ? SC_TX_ACK : SC_TX_NACK;
                        end
                    end
                endcase
            end
            FSM_STOP: if (tick) begin
                case (s_ff.phase)
                    2'd0: begin
                        nxt_s.sdaPull = 1'b1;
                        nxt_s.phase   = 2'd1;
                    end
                    2'd1: begin
                        nxt_s.sclPull = 1'b0;
                        nxt_s.phase   = 2'd2;
                    end
                    2'd2: if (sclS) begin
                        nxt_s.sdaPull = 1'b0;
                        nxt_s.phase   = 2'd3;
                    end
                    default: begin
                        nxt_s.sto    = 1'b0;
                        nxt_s.owner  = 1'b0;
                        nxt_s.status = SC_NO_INFO;
                        nxt_s.phase  = 2'd0;
                        stopDone     = 1'b1;
                        // stop plus start: a fresh start follows
                        nxt_s.fsm = s_ff.sta ? FSM_START : FSM_IDLE;
                    end
                endcase
            end
            default: nxt_s.fsm = FSM_IDLE;
        endcase

        // lost arbitration: let go of both lines at once
        if (arbLost) begin
            nxt_s.sclPull = 1'b0;
            nxt_s.sdaPull = 1'b0;
            nxt_s.owner   = 1'b0;
            nxt_s.phase   = 2'd0;
            nxt_s.fsm     = FSM_IDLE;
            setDone       = 1'b1;
            doneCode      = SC_ARB_LOST;
        end

        // hardware set wins over a same-cycle software clear
        if (setDone) begin
            nxt_s.done             = 1'b1;
            nxt_s.status           = doneCode;
            nxt_s.irqStat[IRQ_DONE] = 1'b1;
        end
        if (arbLost) begin
            nxt_s.irqStat[IRQ_ARB] = 1'b1;
        end
        if (stopDone) begin
            nxt_s.irqStat[IRQ_STOP] = 1'b1;
        end

        // disabled interface drops the bus and the engine
        if (!s_ff.en) begin
            nxt_s.fsm     = FSM_IDLE;
            nxt_s.sclPull = 1'b0;
            nxt_s.sdaPull = 1'b0;
            nxt_s.owner   = 1'b0;
            nxt_s.busy    = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            s_ff         <= '0;
            s_ff.fsm     <= FSM_IDLE;
            s_ff.status  <= SC_NO_INFO;
            s_ff.sclPrev <= 1'b1;
            s_ff.sdaPrev <= 1'b1;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign apbRsp.pready  = access;
    assign apbRsp.pslverr = access && !isMapped(apbReq.paddr);
    assign apbRsp.prdata  = s_ff.prdata;

    // open drain: output level fixed low, enable pulls the line
    assign pads.sclOut = 1'b0;
    assign pads.sclOe  = s_ff.sclPull;
    assign pads.sdaOut = 1'b0;
    assign pads.sdaOe  = s_ff.sdaPull;

    assign irq = (|(s_ff.irqStat & s_ff.irqMask)) || (s_ff.done && s_ff.ie);

endmodule

// >>> hw/twowire_pkg.sv
// shared constants, register map, status codes and carrier types
// assumes a 100 MHz sys_clk and an apb master with 32-bit data
package twowire_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS  = 10;
    localparam int BIT_TIME_NS    = 10000;
    localparam int QUARTER_CYCLES = BIT_TIME_NS / CLK_PERIOD_NS / 4;

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam int          ADDR_W        = 8;
    localparam logic [7:0]  ADDR_CONTROL  = 8'h00;
    localparam logic [7:0]  ADDR_STATUS   = 8'h04;
    localparam logic [7:0]  ADDR_DATA     = 8'h08;
    localparam logic [7:0]  ADDR_IRQ_STAT = 8'h0C;
    localparam logic [7:0]  ADDR_IRQ_MASK = 8'h10;

    // control_reg bit positions
    localparam int CTL_DONE  = 7;
    localparam int CTL_ACKEN = 6;
    localparam int CTL_START = 5;
    localparam int CTL_STOP  = 4;
    localparam int CTL_WCOL  = 3;
    localparam int CTL_EN    = 2;
    localparam int CTL_IE    = 0;

    // irq status / mask bit positions
    localparam int IRQ_W     = 3;
    localparam int IRQ_DONE  = 0;
    localparam int IRQ_ARB   = 1;
    localparam int IRQ_STOP  = 2;

    // ------------------------------------------------------------
    // status codes, prescaler bits always zero
    // ------------------------------------------------------------
    localparam logic [7:0] SC_START    = 8'h08;
    localparam logic [7:0] SC_RSTART   = 8'h10;
    localparam logic [7:0] SC_AW_ACK   = 8'h18;
    localparam logic [7:0] SC_AW_NACK  = 8'h20;
    localparam logic [7:0] SC_TX_ACK   = 8'h28;
    localparam logic [7:0] SC_TX_NACK  = 8'h30;
    localparam logic [7:0] SC_ARB_LOST = 8'h38;
    localparam logic [7:0] SC_AR_ACK   = 8'h40;
    localparam logic [7:0] SC_AR_NACK  = 8'h48;
    localparam logic [7:0] SC_RX_ACK   = 8'h50;
    localparam logic [7:0] SC_RX_NACK  = 8'h58;
    localparam logic [7:0] SC_NO_INFO  = 8'hF8;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        FSM_IDLE  = 3'b000,
        FSM_START = 3'b001,
        FSM_HOLD  = 3'b010,
        FSM_TXB   = 3'b011,
        FSM_TACK  = 3'b100,
        FSM_RXB   = 3'b101,
        FSM_RACK  = 3'b110,
        FSM_STOP  = 3'b111
    } fsm_t;

    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0]       pwdata;
    } apb_req_t;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } apb_rsp_t;

    typedef struct packed {
        logic sclOut;
        logic sclOe;
        logic sdaOut;
        logic sdaOe;
    } pad_out_t;

endpackage

// >>> hw/pin_sync.sv
// three-flop synchroniser for asynchronous pin levels
// assumes inputs come from outside sys_clk domain
module pin_sync
    import twowire_pkg::*;
#(
    parameter int WIDTH = 2,
    parameter logic [WIDTH-1:0] INIT = '1
) (
    input  wire logic             sys_clk,
    input  wire logic             rstn,
    input  wire logic [WIDTH-1:0] pinIn,
    output logic      [WIDTH-1:0] pinOut
);
    logic [WIDTH-1:0] s1_ff, s2_ff, s3_ff, out_ff;

    // a change counts once stages two and three agree
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            s1_ff  <= INIT;
            s2_ff  <= INIT;
            s3_ff  <= INIT;
            out_ff <= INIT;
        end else begin
            s1_ff <= pinIn;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            for (int i = 0; i < WIDTH; i++) begin
                if (s2_ff[i] == s3_ff[i]) begin
                    out_ff[i] <= s3_ff[i];
                end
            end
        end
    end

    assign pinOut = out_ff;
endmodule

// >>> hw/tick_divider.sv
// quarter-bit enable pulse generator
// assumes one sys_clk domain; tick is one cycle wide
module tick_divider
    import twowire_pkg::*;
#(
    parameter int DIV = QUARTER_CYCLES
) (
    input  wire logic sys_clk,
    input  wire logic rstn,
    output logic      tick
);
    localparam int CW = $clog2(DIV + 1);
    logic [CW-1:0] cnt_ff;
    logic          tick_ff;

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            cnt_ff  <= '0;
            tick_ff <= 1'b0;
        end else if (cnt_ff == CW'(DIV - 1)) begin
            cnt_ff  <= '0;
            tick_ff <= 1'b1;
        end else begin
            cnt_ff  <= cnt_ff + CW'(1);
            tick_ff <= 1'b0;
        end
    end

    assign tick = tick_ff;
endmodule

// >>> testbench/twowire_slave_model.sv
// slave transmitter stand-in: acks any address byte, then sends base+n
// assumes pulled-up bus levels on scl and sda; sdaOe pulls sda low
module twowire_slave_model (
    input  wire logic       scl,
    input  wire logic       sda,
    input  wire logic [7:0] base,
    output logic            sdaOe
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] sh, tx;
    int         n;
    // ------------------------------------------------------------
    // behaviour
    // ------------------------------------------------------------
    initial begin
        sdaOe = 1'b0;
        forever begin
            @(negedge sda iff scl);
            n = 0;
            repeat (8) @(posedge scl) sh = {sh[6:0], sda};
            @(negedge scl) sdaOe = 1'b1;
            @(negedge scl) sdaOe = 1'b0;
            // read bit picks the direction
            while (sh[0]) begin
                tx = base + 8'(n);
                n++;
                for (int i = 7; i >= 0; i--) begin
                    sdaOe = !tx[i];
                    @(negedge scl);
                end
                sdaOe = 1'b0;
                @(posedge scl) sh[0] = !sda;
                @(negedge scl);
            end
        end
    end
endmodule

// >>> testbench/twowire_mr_properties.sv
// port assertions for the master receiver
// assumes it is bound to each twowire_master_receiver
module twowire_mr_properties
    import twowire_pkg::*;
(
    input wire logic     sys_clk,
    input wire logic     rstn,
    input wire apb_req_t apbReq,
    input wire apb_rsp_t apbRsp,
    input wire logic     sclIn,
    input wire logic     sdaIn,
    input wire pad_out_t pads,
    input wire logic     irq
);
    timeunit 1ns;
    timeprecision 1ns;
    logic        acc, hit, ctlRd;
    logic [31:0] q;
    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    assign acc = apbReq.psel && apbReq.penable;
    assign hit = apbReq.paddr inside {ADDR_CONTROL, ADDR_STATUS, ADDR_DATA,
                                      ADDR_IRQ_STAT, ADDR_IRQ_MASK};
    assign ctlRd = acc && !apbReq.pwrite && apbReq.paddr == ADDR_CONTROL;
    assign q = apbRsp.prdata;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    zero_wait_a: assert property (acc |-> apbRsp.pready)
        else $error("pready low in access");
    err_where_a: assert property (apbRsp.pslverr |-> acc && !hit)
        else $error("pslverr misplaced");
    err_need_a: assert property (acc && !hit |-> apbRsp.pslverr)
        else $error("unmapped not refused");
    status_low_a: assert property (acc && !apbReq.pwrite && apbReq.paddr == ADDR_STATUS
        |-> q[1:0] == 2'b00) else $error("status low bits set");
    reserved_zero_a: assert property (ctlRd |-> !q[1] && q[31:8] == 24'h0)
        else $error("control reserved bits set");
    irq_done_a: assert property (ctlRd && q[CTL_DONE] && q[CTL_IE] |-> irq)
        else $error("irq low with done");
    drop_bus_a: assert property (acc && apbReq.pwrite && apbReq.paddr == ADDR_CONTROL
        && !apbReq.pwdata[CTL_EN] |-> ##[1:3] !pads.sclOe && !pads.sdaOe)
        else $error("bus kept when disabled");
    open_drain_a: assert property (!pads.sclOut && !pads.sdaOut)
        else $error("pad driven high");
endmodule

bind twowire_master_receiver twowire_mr_properties chk_u (
    .sys_clk(sys_clk), .rstn(rstn), .apbReq(apbReq), .apbRsp(apbRsp),
    .sclIn(sclIn), .sdaIn(sdaIn), .pads(pads), .irq(irq));

// >>> testbench/twowire_master_receiver_tb.sv
// self-checking bench: apb master, slave model, expected-byte queue
// assumes package, design, slave model and checker compile first
module twowire_master_receiver_tb
    import twowire_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        sysClk;
    logic        rstn;
    apb_req_t    req;
    apb_rsp_t    rsp;
    pad_out_t    pads;
    logic        irq;
    logic        slvOe;
    logic        scl;
    logic        sda;
    logic [7:0]  base;
    logic [6:0]  addr;
    logic [31:0] rd;
    logic [7:0]  exp[$];
    int          nb;
    int          mismatches;
    int          cmp_count;
    logic [7:0]  regA[6] = '{ADDR_CONTROL, ADDR_STATUS, ADDR_DATA, ADDR_IRQ_STAT,
                             ADDR_IRQ_MASK, 8'h14};
    logic [31:0] regV[6] = '{32'h0, 32'h0000_00f8, 32'h0, 32'h0, 32'h0, 32'h0};
    // both lines pulled up; any enable pulls low
    assign scl = !pads.sclOe;
    assign sda = !(pads.sdaOe || slvOe);
    twowire_master_receiver #(.QUARTER(4)) dut_u (.sys_clk(sysClk), .rstn(rstn),
        .apbReq(req), .apbRsp(rsp), .sclIn(scl), .sdaIn(sda), .pads(pads), .irq(irq));
    twowire_slave_model slv_u (.scl(scl), .sda(sda), .base(base), .sdaOe(slvOe));
    always #5 sysClk = !sysClk;
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic final_report();
        $display("checks %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge sysClk);
        req.penable <= 1'b1;
        do begin
            @(posedge sysClk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 20);
        rd = rsp.prdata;
        req <= '0;
        @(posedge sysClk);
        if (n >= 20) begin
            chk("pready bound", 32'h1, 32'h0);
            final_report();
        end
    endtask
    // polling keeps the bench blind to exact bus timing
    task automatic poll(input int b, input logic v);
        int n = 0;
        do begin
            apb(1'b0, ADDR_CONTROL, 32'h0);
            n++;
        end while (rd[b] !== v && n < 400);
        if (rd[b] !== v) begin
            chk("poll bound", 32'h1, 32'h0);
            final_report();
        end
    endtask
    task automatic chkst(input logic [7:0] e);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk("status", {24'h0, e}, rd);
    endtask
    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        sysClk = 1'b0;
        rstn = 1'b0;
        req = '0;
        base = 8'h00;
        void'($urandom(32'h1315_3c68));
        repeat (2) @(posedge sysClk);
        rstn <= 1'b1;
        @(posedge sysClk);
        foreach (regA[i]) begin
            apb(1'b0, regA[i], 32'h0);
            chk("reset value", regV[i], rd);
        end
        $display("test reset values done");
        for (int t = 0; t < 2; t++) begin
            nb = $urandom_range(1, 3);
            base = 8'($urandom);
            addr = 7'($urandom);
            apb(1'b1, ADDR_CONTROL, 32'h0000_00a4);
            poll(CTL_DONE, 1'b1);
            chkst(t == 0 ? SC_START : SC_RSTART);
            apb(1'b1, ADDR_CONTROL, 32'h0000_0005);
            apb(1'b0, ADDR_CONTROL, 32'h0);
            chk("done kept", 32'h81, rd & 32'h81);
            chk("irq", 32'h1, {31'h0, irq});
            apb(1'b1, ADDR_DATA, {24'h0, addr, 1'b1});
            apb(1'b1, ADDR_CONTROL, 32'h0000_0084);
            poll(CTL_DONE, 1'b1);
            chkst(SC_AR_ACK);
            for (int j = 0; j < nb; j++) begin
                exp.push_back(base + 8'(j));
                apb(1'b1, ADDR_CONTROL, j < nb - 1 ? 32'h0000_00c4 : 32'h0000_0084);
                poll(CTL_DONE, 1'b1);
                chkst(j < nb - 1 ? SC_RX_ACK : SC_RX_NACK);
                apb(1'b0, ADDR_DATA, 32'h0);
                chk("data", {24'h0, exp.pop_front()}, rd);
            end
            $display("test transfer %0d done", t);
        end
        apb(1'b1, ADDR_CONTROL, 32'h0000_0094);
        poll(CTL_STOP, 1'b0);
        chk("done after stop", 32'h0, rd & 32'h80);
        chkst(SC_NO_INFO);
        apb(1'b0, ADDR_IRQ_STAT, 32'h0);
        chk("irq status", 32'h5, rd);
        apb(1'b1, ADDR_IRQ_MASK, 32'h0000_0005);
        chk("irq unmasked", 32'h1, {31'h0, irq});
        apb(1'b1, ADDR_IRQ_STAT, 32'h0000_0007);
        chk("irq cleared", 32'h0, {31'h0, irq});
        apb(1'b1, ADDR_DATA, 32'h0);
        poll(CTL_WCOL, 1'b1);
        apb(1'b1, ADDR_CONTROL, 32'h0000_00a4);
        poll(CTL_DONE, 1'b1);
        apb(1'b1, ADDR_CONTROL, 32'h0);
        $display("test stop and irq done");
        final_report();
    end
endmodule
